// *** rtl/charge_switch_ctrl.sv ***
// module: battery charge switch controller with wishbone registers
`timescale 1ns/10ps

// Contract
// - algorithm 0 nickel, 1 lithium with temperature
// - nickel: sample open, pulse if below full
// - nickel: rest interval after each pulse
// - nickel: pulse lasts programmed pulse time
// - nickel full: stay open, check per monitor
// - nickel times and threshold are programmable
// - lithium: closed until pulse start threshold
// - lithium pulses one second, 100 ms rests
// - fixed rests until rest voltage exceeds full
// - rest above full enters final phase
// - final phase: rest extends while above 4.2V
// - final rest grows from 100ms to 10s
// - stop lithium at full and 10s rest
// - rest beyond 10 seconds ends the charge; the code ends it on reaching 10 s
// - pre-charge with charger, battery 2.8-3.2V
// - pre-charge only when off, hardware only
// - sustaining battery powers on, starts algorithm
// - blink indicator while pre-charge active
// - lithium: compare temperature with programmed limits
// - registers select type, parameters, start, stop
// - single output drives the charge switch
module charge_switch_ctrl #(
  parameter int TICK_CYCLES = chg_pkg::TICK_CYCLES  // cycles per tick
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // battery and charger sense
  input wire logic chargerPresent,
  input wire logic [15:0] batteryMv,
  input wire logic [11:0] battTempCode,
  input wire logic moduleOn,
  // switch, pre-charge and indicator
  output logic chargeSwitch,
  output logic preChargeEn,
  output logic chargeIndicatorLed,
  output logic powerOnReq
);

  // ***************************************************************
  // declarations
  // ***************************************************************
  logic [31:0] tickCntQ;  // prescaler count
  logic tickQ;  // one-cycle 100 ms enable
  chg_pkg::chg_state_type stateQ, stateD;  // controller state
  logic [15:0] timerQ;  // ticks spent in current state
  logic phase3Q;  // lithium final phase reached
  logic algoQ;  // selected algorithm
  logic [15:0] pulseQ, restQ, monitorQ, fullQ, pstartQ;  // settings
  logic [11:0] tempLoQ, tempHiQ;  // temperature window
  logic doneQ, tFaultQ;  // sticky events
  logic startCmd, stopCmd;  // command pulses from writes
  logic autoStart;  // power-on hand over
  logic moduleOnQ;  // previous moduleOn for edge
  logic preQ;  // pre-charge seen before power on
  logic busReq, wrStb;  // bus access qualifiers
  logic tempBad;  // temperature outside window
  logic enterDone, enterTemp;  // event sources
  logic preActive;  // pre-charge condition
  logic startAlgo;  // algorithm taken by a start in this cycle

  // true once the state has lasted cfg ticks (zero acts as one)
  function automatic logic expired(input logic [15:0] t,
                                   input logic [15:0] cfg);
    expired = ({1'b0, t} + 17'h0_0001) >= {1'b0, cfg};
  endfunction

  // switch closed in these states only
  function automatic logic closedIn(input chg_pkg::chg_state_type s);
    closedIn = (s == chg_pkg::ST_NI_PULSE) ||
               (s == chg_pkg::ST_LI_CONT) ||
               (s == chg_pkg::ST_LI_PULSE);
  endfunction

  // ***************************************************************
  // time base
  // ***************************************************************
  // prescaler: a single enable rather than a derived clock
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tickCntQ <= 32'h0000_0000;
      tickQ <= 1'b0;
    end else if (tickCntQ >= 32'(TICK_CYCLES - 1)) begin
      tickCntQ <= 32'h0000_0000;
      tickQ <= 1'b1;
    end else begin
      tickCntQ <= tickCntQ + 32'h0000_0001;
      tickQ <= 1'b0;
    end
  end

  // ***************************************************************
  // wishbone slave
  // ***************************************************************
  assign busReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wrStb = busReq && wb_we_i && wb_sel_i[0];
  assign startCmd = wrStb && (wb_adr_i == chg_pkg::OFS_CTRL) &&
                    wb_dat_i[chg_pkg::CTRL_START];
  assign stopCmd = wrStb && (wb_adr_i == chg_pkg::OFS_CTRL) &&
                   wb_dat_i[chg_pkg::CTRL_STOP];

  // ack one cycle after the request, dropped the next cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= busReq;
    end
  end

  // configuration writes; low byte lane gates whole-register writes
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      algoQ <= 1'b0;
      pulseQ <= chg_pkg::RST_PULSE;
      restQ <= chg_pkg::RST_REST;
      monitorQ <= chg_pkg::RST_MONITOR;
      fullQ <= chg_pkg::RST_FULL;
      pstartQ <= chg_pkg::RST_PSTART;
      tempLoQ <= chg_pkg::RST_TEMPLO;
      tempHiQ <= chg_pkg::RST_TEMPHI;
    end else if (wrStb) begin
      unique case (wb_adr_i)
        chg_pkg::OFS_CTRL: begin
          algoQ <= wb_dat_i[chg_pkg::CTRL_ALGO];
        end
        chg_pkg::OFS_PULSE: pulseQ <= wb_dat_i[15:0];
        chg_pkg::OFS_REST: restQ <= wb_dat_i[15:0];
        chg_pkg::OFS_MONITOR: monitorQ <= wb_dat_i[15:0];
        chg_pkg::OFS_FULL: fullQ <= wb_dat_i[15:0];
        chg_pkg::OFS_PSTART: pstartQ <= wb_dat_i[15:0];
        chg_pkg::OFS_TEMPLO: tempLoQ <= wb_dat_i[11:0];
        chg_pkg::OFS_TEMPHI: tempHiQ <= wb_dat_i[11:0];
        default: ;  // unmapped or status: no stored effect here
      endcase
    end
  end

  // read data registered with the ack; unmapped reads zero
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (busReq && !wb_we_i) begin
      unique case (wb_adr_i)
        chg_pkg::OFS_CTRL: wb_dat_o <= {31'h0000_0000, algoQ};
        chg_pkg::OFS_STATUS: begin
          wb_dat_o <= {23'h00_0000, preActive, phase3Q, chargeSwitch,
                       tFaultQ, doneQ, 4'(stateQ)};
        end
        chg_pkg::OFS_PULSE: wb_dat_o <= {16'h0000, pulseQ};
        chg_pkg::OFS_REST: wb_dat_o <= {16'h0000, restQ};
        chg_pkg::OFS_MONITOR: wb_dat_o <= {16'h0000, monitorQ};
        chg_pkg::OFS_FULL: wb_dat_o <= {16'h0000, fullQ};
        chg_pkg::OFS_PSTART: wb_dat_o <= {16'h0000, pstartQ};
        chg_pkg::OFS_TEMPLO: wb_dat_o <= {20'h0_0000, tempLoQ};
        chg_pkg::OFS_TEMPHI: wb_dat_o <= {20'h0_0000, tempHiQ};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // ***************************************************************
  // pre-charge and power-on hand over
  // ***************************************************************
  // pure hardware path: no register takes part in it
  assign preActive = !moduleOn && chargerPresent &&
                     (batteryMv >= chg_pkg::PRE_LOW_MV) &&
                     (batteryMv <= chg_pkg::PRE_HIGH_MV);

  // pre-charge enable, blink and power-on request
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      preChargeEn <= 1'b0;
      chargeIndicatorLed <= 1'b0;
      powerOnReq <= 1'b0;
      preQ <= 1'b0;
      moduleOnQ <= 1'b0;
    end else begin
      moduleOnQ <= moduleOn;
      preChargeEn <= preActive;
      if (!preActive) begin
        chargeIndicatorLed <= 1'b0;
      end else if (tickQ) begin
        chargeIndicatorLed <= !chargeIndicatorLed;
      end
      // battery above the window can carry the module: ask power-on
      powerOnReq <= !moduleOn && chargerPresent &&
                    (batteryMv > chg_pkg::PRE_HIGH_MV) &&
                    (preQ || preActive);
      if (preActive) begin
        preQ <= 1'b1;
      end else if (moduleOn && moduleOnQ) begin
        preQ <= 1'b0;
      end
    end
  end

  // start the selected algorithm once the module has come up
  assign autoStart = moduleOn && !moduleOnQ && preQ &&
                     chargerPresent;

  // ***************************************************************
  // charge state machine
  // ***************************************************************
  // temperature only matters with lithium selected
  assign tempBad = algoQ && ((battTempCode < tempLoQ) ||
                             (battTempCode > tempHiQ));

  // a ctrl write carrying start also selects the algorithm, so the
  // start must follow the written bit, not the stale register
  assign startAlgo = startCmd ? wb_dat_i[chg_pkg::CTRL_ALGO]
                              : algoQ;

  // next state
  always_comb begin
    stateD = stateQ;
    if (stopCmd || !moduleOn) begin
      stateD = chg_pkg::ST_IDLE;
    end else begin
      unique case (stateQ)
        chg_pkg::ST_IDLE, chg_pkg::ST_FINISHED: begin
          if (startCmd || autoStart) begin
            stateD = startAlgo ? chg_pkg::ST_LI_CONT
                               : chg_pkg::ST_NI_REST;
          end
        end
        chg_pkg::ST_NI_REST: begin
          // sample only while open, at the end of the rest
          if (tickQ && expired(timerQ, restQ)) begin
            stateD = (batteryMv < fullQ) ? chg_pkg::ST_NI_PULSE
                                         : chg_pkg::ST_NI_MONITOR;
          end
        end
        chg_pkg::ST_NI_PULSE: begin
          if (tickQ && expired(timerQ, pulseQ)) begin
            stateD = chg_pkg::ST_NI_REST;
          end
        end
        chg_pkg::ST_NI_MONITOR: begin
          // open; checks each tick once the monitor interval has passed, pulse if sagged
          if (tickQ && expired(timerQ, monitorQ) &&
              (batteryMv < fullQ)) begin
            stateD = chg_pkg::ST_NI_PULSE;
          end
        end
        chg_pkg::ST_LI_CONT: begin
          if (tempBad) begin
            stateD = chg_pkg::ST_LI_TEMPHOLD;
          end else if (batteryMv >= pstartQ) begin
            stateD = chg_pkg::ST_LI_PULSE;
          end
        end
        chg_pkg::ST_LI_PULSE: begin
          if (tempBad) begin
            stateD = chg_pkg::ST_LI_TEMPHOLD;
          end else if (tickQ && expired(timerQ, chg_pkg::LI_PULSE)) begin
            stateD = chg_pkg::ST_LI_REST;
          end
        end
        chg_pkg::ST_LI_REST: begin
          if (tempBad) begin
            stateD = chg_pkg::ST_LI_TEMPHOLD;
          end else if (phase3Q && (batteryMv > chg_pkg::LI_HOLD_MV)) begin
            // rest keeps growing; reaching 10 s finishes the charge
            if (tickQ && expired(timerQ, chg_pkg::LI_REST_LIMIT)) begin
              stateD = chg_pkg::ST_FINISHED;
            end
          end else if (tickQ && expired(timerQ, chg_pkg::LI_REST_MIN)) begin
            stateD = chg_pkg::ST_LI_PULSE;
          end
        end
        chg_pkg::ST_LI_TEMPHOLD: begin
          // resume through continuous charge, which re-checks voltage
          if (!tempBad) begin
            stateD = chg_pkg::ST_LI_CONT;
          end
        end
        default: stateD = chg_pkg::ST_IDLE;
      endcase
    end
  end

  // state register and per-state tick timer
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      stateQ <= chg_pkg::ST_IDLE;
      timerQ <= 16'h0000;
    end else begin
      stateQ <= stateD;
      if (stateD != stateQ) begin
        timerQ <= 16'h0000;
      end else if (tickQ && (timerQ != 16'hffff)) begin
        timerQ <= timerQ + 16'h0001;
      end
    end
  end

  // final phase flag: rest voltage above full threshold
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      phase3Q <= 1'b0;
    end else if (stateD == chg_pkg::ST_IDLE ||
                 stateQ == chg_pkg::ST_IDLE) begin
      phase3Q <= 1'b0;
    end else if (stateQ == chg_pkg::ST_LI_REST &&
                 batteryMv > fullQ) begin
      phase3Q <= 1'b1;
    end
  end

  // the one switch output, registered from the next state
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      chargeSwitch <= 1'b0;
    end else begin
      chargeSwitch <= closedIn(stateD);
    end
  end

  // ***************************************************************
  // sticky status events
  // ***************************************************************
  assign enterDone = (stateD == chg_pkg::ST_FINISHED) &&
                     (stateQ != chg_pkg::ST_FINISHED);
  assign enterTemp = (stateD == chg_pkg::ST_LI_TEMPHOLD) &&
                     (stateQ != chg_pkg::ST_LI_TEMPHOLD);

  // write one to clear; a new event in the same cycle wins
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      doneQ <= 1'b0;
      tFaultQ <= 1'b0;
    end else begin
      if (enterDone) begin
        doneQ <= 1'b1;
      end else if (wrStb && wb_adr_i == chg_pkg::OFS_STATUS &&
                   wb_dat_i[chg_pkg::ST_DONE]) begin
        doneQ <= 1'b0;
      end
      if (enterTemp) begin
        tFaultQ <= 1'b1;
      end else if (wrStb && wb_adr_i == chg_pkg::OFS_STATUS &&
                   wb_dat_i[chg_pkg::ST_TFAULT]) begin
        tFaultQ <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // assertions
  // ***************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_switch_state: assert property (
    chargeSwitch == closedIn(stateQ))
    else $error("switch disagrees with state");
  a_tick_spacing: assert property (
    tickQ |=> !tickQ)
    else $error("tick not a single pulse");
  a_ni_sample_open: assert property (
    stateQ == chg_pkg::ST_NI_REST && stateD == chg_pkg::ST_NI_PULSE
    |-> !chargeSwitch && batteryMv < fullQ)
    else $error("pulse started without open low sample");
  a_ni_monitor_open: assert property (
    stateQ == chg_pkg::ST_NI_MONITOR |-> !chargeSwitch)
    else $error("switch closed while monitoring");
  a_li_cont_closed: assert property (
    stateQ == chg_pkg::ST_LI_CONT && !tempBad &&
    batteryMv < pstartQ && moduleOn && !stopCmd
    |=> chargeSwitch)
    else $error("continuous phase left early");
  a_li_pulse_len: assert property (
    stateQ == chg_pkg::ST_LI_PULSE && stateD == chg_pkg::ST_LI_REST
    |-> timerQ == chg_pkg::LI_PULSE - 16'h0001)
    else $error("lithium pulse not one second");
  a_rest_limit: assert property (
    stateQ == chg_pkg::ST_LI_REST |-> timerQ < chg_pkg::LI_REST_LIMIT)
    else $error("rest exceeded ten seconds");
  a_temp_open: assert property (
    tempBad && closedIn(stateQ) && moduleOn && !stopCmd
    && stateQ != chg_pkg::ST_NI_PULSE
    |=> stateQ == chg_pkg::ST_LI_TEMPHOLD ##0 !chargeSwitch)
    else $error("switch not opened on temperature fault");
  a_done_sticky: assert property (
    enterDone |=> doneQ)
    else $error("completion not flagged");
  a_pre_off_only: assert property (
    preChargeEn |-> !$past(moduleOn))
    else $error("pre-charge while module on");
  a_led_quiet: assert property (
    !preChargeEn ##1 !preChargeEn |-> !chargeIndicatorLed)
    else $error("indicator blinking outside pre-charge");

  c_ni_pulse: cover property (
    stateQ == chg_pkg::ST_NI_PULSE ##1 stateQ == chg_pkg::ST_NI_REST);
  c_li_finish: cover property (enterDone);
  c_temp_hold: cover property (enterTemp);
  c_precharge: cover property (preChargeEn && chargeIndicatorLed);

endmodule  // charge_switch_ctrl

// *** rtl/chg_pkg.sv ***
// package: constants and types for the battery charge switch controller
package chg_pkg;

  // ***************************************************************
  // time base
  // ***************************************************************
  localparam int CLK_HZ = 40_000_000;  // clk_sys rate
  localparam int TICK_MS = 100;  // tick resolution in milliseconds
  // cycles per tick, exact at 40 MHz
  localparam int TICK_CYCLES = (CLK_HZ / 1000) * TICK_MS;

  // ***************************************************************
  // register byte offsets (wishbone word aligned)
  // ***************************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;  // algorithm, start, stop
  localparam logic [7:0] OFS_STATUS = 8'h04;  // state and sticky events
  localparam logic [7:0] OFS_PULSE = 8'h08;  // charge_pulse_time, ticks
  localparam logic [7:0] OFS_REST = 8'h0c;  // rest_interval, ticks
  localparam logic [7:0] OFS_MONITOR = 8'h10;  // monitor_interval, ticks
  localparam logic [7:0] OFS_FULL = 8'h14;  // full_charge_threshold, mV
  localparam logic [7:0] OFS_PSTART = 8'h18;  // pulse_start_threshold, mV
  localparam logic [7:0] OFS_TEMPLO = 8'h1c;  // lower temperature code
  localparam logic [7:0] OFS_TEMPHI = 8'h20;  // upper temperature code

  // ***************************************************************
  // field positions
  // ***************************************************************
  localparam int CTRL_ALGO = 0;  // 0 nickel, 1 lithium
  localparam int CTRL_START = 1;  // write 1: start command
  localparam int CTRL_STOP = 2;  // write 1: stop command
  localparam int ST_DONE = 4;  // sticky charge complete
  localparam int ST_TFAULT = 5;  // sticky temperature fault
  localparam int ST_SWITCH = 6;  // live switch state
  localparam int ST_PHASE3 = 7;  // live final phase flag
  localparam int ST_PRECHG = 8;  // live pre-charge flag

  // ***************************************************************
  // reset values (ticks of 100 ms, voltages in mV)
  // ***************************************************************
  localparam logic [15:0] RST_PULSE = 16'h000a;  // 1 s
  localparam logic [15:0] RST_REST = 16'h0001;  // 100 ms
  localparam logic [15:0] RST_MONITOR = 16'h0032;  // 5 s
  localparam logic [15:0] RST_FULL = 16'h10cc;  // 4300 mV
  localparam logic [15:0] RST_PSTART = 16'h0fa0;  // 4000 mV
  localparam logic [11:0] RST_TEMPLO = 12'h100;
  localparam logic [11:0] RST_TEMPHI = 12'h600;

  // ***************************************************************
  // fixed lithium and pre-charge figures
  // ***************************************************************
  localparam logic [15:0] LI_PULSE = 16'h000a;  // 1 s pulse
  localparam logic [15:0] LI_REST_MIN = 16'h0001;  // 100 ms rest
  localparam logic [15:0] LI_REST_LIMIT = 16'h0064;  // 10 s rest
  localparam logic [15:0] LI_HOLD_MV = 16'h1068;  // 4200 mV
  localparam logic [15:0] PRE_LOW_MV = 16'h0af0;  // 2800 mV
  localparam logic [15:0] PRE_HIGH_MV = 16'h0c80;  // 3200 mV

  // ***************************************************************
  // controller states
  // ***************************************************************
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_NI_REST,
    ST_NI_PULSE,
    ST_NI_MONITOR,
    ST_LI_CONT,
    ST_LI_PULSE,
    ST_LI_REST,
    ST_LI_TEMPHOLD,
    ST_FINISHED
  } chg_state_type;

endpackage

// *** verif/battery_pack_model.sv ***
// battery pack model: terminal voltage seen by the controller
`timescale 1ns/10ps
module battery_pack_model (
  // switch from the controller
  input wire logic chargeSwitch,
  // open-circuit voltage set by the bench
  input wire logic [15:0] restMv,
  // sensed terminal voltage
  output logic [15:0] batteryMv
);
  // a closed switch lifts the terminal by 100 mV, so sampling
  // while closed would read falsely high
  assign batteryMv = restMv + (chargeSwitch ? 16'h0064 : 16'h0000);
endmodule // battery_pack_model

// *** verif/charge_switch_ctrl_tb_top.sv ***
// testbench: register access and charge switch timing checks
`timescale 1ns/10ps
module charge_switch_ctrl_tb_top;
  // ************************************************
  // signals
  // ************************************************
  localparam int TK = 4; // short tick keeps the run brief
  localparam logic [7:0] OFS [10] = '{chg_pkg::OFS_CTRL,
    chg_pkg::OFS_STATUS, chg_pkg::OFS_PULSE, chg_pkg::OFS_REST,
    chg_pkg::OFS_MONITOR, chg_pkg::OFS_FULL, chg_pkg::OFS_PSTART,
    chg_pkg::OFS_TEMPLO, chg_pkg::OFS_TEMPHI, 8'h40};
  localparam logic [15:0] RV [10] = '{16'h0000, 16'h0000,
    chg_pkg::RST_PULSE, chg_pkg::RST_REST, chg_pkg::RST_MONITOR,
    chg_pkg::RST_FULL, chg_pkg::RST_PSTART, 16'(chg_pkg::RST_TEMPLO),
    16'(chg_pkg::RST_TEMPHI), 16'h0000};
  logic clk_sys, rst_n, cyc, we, ack, chg, on, sw, pre, led, pwr, lastLed;
  logic [7:0] adr; // bus address
  logic [31:0] dw, dr, v; // write, read, captured data
  logic [15:0] restMv, batMv; // open-circuit and sensed voltage
  logic [11:0] temp; // temperature code
  int err_total, num_checks, n;

  charge_switch_ctrl #(.TICK_CYCLES(TK)) u_charge_switch_ctrl (
    .clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dw),
    .wb_dat_o(dr), .wb_ack_o(ack), .chargerPresent(chg),
    .batteryMv(batMv), .battTempCode(temp), .moduleOn(on),
    .chargeSwitch(sw), .preChargeEn(pre), .chargeIndicatorLed(led),
    .powerOnReq(pwr));
  battery_pack_model u_battery_pack_model (
    .chargeSwitch(sw), .restMv(restMv), .batteryMv(batMv));

  // 40 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // ************************************************
  // tasks
  // ************************************************
  // one classic cycle; request held until ack is sampled
  task automatic wbCycle(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dw <= d;
    do @(posedge clk_sys); while (ack !== 1'b1);
    v = dr;
    cyc <= 1'b0;
    we <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic chkEq(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkIn(input logic [31:0] got, input int lo, hi);
    num_checks++;
    if ($isunknown(got) || !(got >= lo && got <= hi)) begin
      err_total++;
      $display("Error at %0t: got %h expected %h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] e, m);
    wbCycle(1'b0, a, 32'h0000_0000);
    chkEq(v & m, e);
  endtask
  task automatic ticks(input int k);
    repeat (k) @(posedge clk_sys);
  endtask
  // length of the next run of the switch at level lvl
  task automatic lenOf(input logic lvl);
    n = 0;
    repeat (900) if (sw !== lvl) @(posedge clk_sys);
    while (sw === lvl && n < 900) begin
      n++;
      @(posedge clk_sys);
    end
  endtask
  task automatic complete_run();
    if (err_total == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // watchdog: the whole sequence needs under 2500 cycles
  initial begin
    ticks(6000);
    err_total++;
    complete_run();
  end

  // ************************************************
  // sequence
  // ************************************************
  initial begin
    {cyc, we, chg, on, rst_n} = '0;
    adr = '0;
    dw = '0;
    restMv = 16'h109a; // 4250 open, 4350 closed
    temp = 12'h300;
    err_total = 0;
    num_checks = 0;
    ticks(16);
    rst_n <= 1'b1;
    on <= 1'b1;
    @(posedge clk_sys);
    chkEq({sw, pre, led, pwr}, 4'h0);
    for (int i = 0; i < 10; i++) rdChk(OFS[i], 32'(RV[i]), 32'h0000_ffff);
    // nickel: sampled only while open, so 4350 closed still pulses
    wbCycle(1'b1, chg_pkg::OFS_PULSE, 32'h0000_0003);
    wbCycle(1'b1, chg_pkg::OFS_REST, 32'h0000_0002);
    wbCycle(1'b1, chg_pkg::OFS_MONITOR, 32'h0000_0003);
    rdChk(chg_pkg::OFS_REST, 32'h0000_0002, 32'h0000_ffff);
    wbCycle(1'b1, chg_pkg::OFS_CTRL, 32'h0000_0002);
    lenOf(1'b1);
    chkIn(n, 9, 12);
    lenOf(1'b0);
    chkIn(n, 5, 10);
    restMv <= 16'h1130; // 4400 mV, full
    ticks(60);
    rdChk(chg_pkg::OFS_STATUS, 32'h0000_0003, 32'h0000_01cf);
    restMv <= 16'h0fa0; // sag below full resumes pulsing
    lenOf(1'b1);
    chkIn(n, 9, 12);
    // lithium: continuous below pulse start
    wbCycle(1'b1, chg_pkg::OFS_CTRL, 32'h0000_0004);
    restMv <= 16'h0f0a; // 3950 mV closed
    wbCycle(1'b1, chg_pkg::OFS_CTRL, 32'h0000_0003);
    ticks(60);
    rdChk(chg_pkg::OFS_STATUS, 32'h0000_0044, 32'h0000_01cf);
    restMv <= 16'h0f6e; // 4050 mV closed
    lenOf(1'b0);
    chkIn(n, 1, 6);
    lenOf(1'b1);
    chkIn(n, 37, 41);
    temp <= 12'h700; // above upper limit
    ticks(20);
    rdChk(chg_pkg::OFS_STATUS, 32'h0000_0027, 32'h0000_01ef);
    temp <= 12'h300;
    ticks(20);
    wbCycle(1'b1, chg_pkg::OFS_STATUS, 32'h0000_0020);
    rdChk(chg_pkg::OFS_STATUS, 32'h0000_0000, 32'h0000_0020);
    // final phase: rest stays open while above 4.2 V
    restMv <= 16'h10fe; // 4350 mV
    ticks(60);
    rdChk(chg_pkg::OFS_STATUS, 32'h0000_0086, 32'h0000_01cf);
    ticks(300);
    rdChk(chg_pkg::OFS_STATUS, 32'h0000_0086, 32'h0000_01cf);
    ticks(120);
    rdChk(chg_pkg::OFS_STATUS, 32'h0000_0018, 32'h0000_015f);
    // pre-charge while off; ctrl write also sets nickel
    wbCycle(1'b1, chg_pkg::OFS_CTRL, 32'h0000_0004);
    on <= 1'b0;
    chg <= 1'b1;
    restMv <= 16'h0bb8; // 3000 mV
    ticks(4);
    chkEq({pre, sw}, 2'b10);
    n = 0;
    lastLed = led;
    repeat (40) begin
      @(posedge clk_sys);
      if (led !== lastLed) n++;
      lastLed = led;
    end
    chkIn(n, 9, 11);
    restMv <= 16'h0d48; // 3400 mV sustains the module
    ticks(4);
    chkEq({pre, pwr}, 2'b01);
    on <= 1'b1;
    ticks(4);
    wbCycle(1'b0, chg_pkg::OFS_STATUS, 32'h0000_0000);
    chkIn(v[3:0], 1, 2);
    complete_run();
  end
endmodule // charge_switch_ctrl_tb_top
